//--- core/evf_pkg.sv
/*
 * evf_pkg: register map, field layout, reset values and timing constants
 * of the encoder velocity filter.
 * Assumes a 32-bit APB slave with word registers at four times the index.
 */
package evf_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_IDLE_TIMEOUT = 8'h62;
	localparam logic [7:0] IDX_FILTER_CFG = 8'h63;
	localparam logic [7:0] IDX_RAW_SPEED = 8'h65;
	localparam logic [7:0] IDX_SMOOTH_SPEED = 8'h66;
	localparam logic [7:0] IDX_EVENT_STATUS = 8'h70;
	localparam logic [7:0] IDX_EVENT_MASK = 8'h71;
	localparam logic [7:0] IDX_ENC_MODE = 8'h72;
	localparam logic [7:0] IDX_POLL_PERIOD = 8'h73;
	// field positions in the filter configuration word
	localparam int WAIT_LSB = 0;
	localparam int WAIT_MSB = 7;
	localparam int SHIFT_LSB = 8;
	localparam int SHIFT_MSB = 11;
	localparam int PERIOD_LSB = 16;
	localparam int PERIOD_MSB = 31;
	// status, mask and mode bits
	localparam int EVT_IDLE_BIT = 0;
	localparam int MODE_ABS_BIT = 0;
	// values after reset
	localparam logic [31:0] RST_IDLE_TIMEOUT = 32'h0000_0000;
	localparam logic [31:0] RST_FILTER_CFG = 32'h0100_0440;
	localparam logic [31:0] RST_POLL_PERIOD = 32'h0000_0100;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	// timing
	localparam longint CLK_HZ = 40000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [31:0] MIN_INC_PERIOD = 32'h0000_0100;
	localparam int DIV_STEPS = 48;
	localparam logic [47:0] CLK_HZ_W = 48'(CLK_HZ);
endpackage

//--- core/evf_core.sv
/*
 * evf_core: encoder velocity measurement, recursive mean filter and idle
 * event, with an APB register slave and a masked interrupt output.
 * Assumes CLK_IN at 40 MHz, encoder A/B pins asynchronous to it, and an
 * absolute-encoder position word with a strobe from logic on CLK_IN.
 */
`timescale 1ns/10ps

// Overview of operation
// - raw encoder speed readable in microsteps per second
// - filtered encoder speed readable as separate register
// - bits 7:0 set filter sample wait cycles
// - absolute mode uses serial poll period for timing
// - bits 11:8 set filter shift exponent
// - mean minus shifted mean plus shifted raw
// - bits 31:16 set high speed update period
// - incremental update period never below 256 cycles
// - incremental low speeds computed on AB transitions only
// - idle timeout without transition raises idle event
module evf_core (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic PREADY_OUT,
	output logic [31:0] PRDATA_OUT,
	output logic PSLVERR_OUT,
	output logic IRQ_OUT,
	input wire logic ENC_A_IN,
	input wire logic ENC_B_IN,
	input wire logic [31:0] ABS_POS_IN,
	input wire logic ABS_POS_VALID_IN
);
	logic [31:0] idle_timeout_ff, filter_cfg_ff, poll_period_ff;
	logic [31:0] status_ff, mask_ff, mode_ff;
	logic [31:0] raw_speed_ff, smooth_speed_ff;
	logic pready_ff, pslverr_ff, irq_ff;
	logic [31:0] prdata_ff;
	logic [2:0] a_sync_ff, b_sync_ff;
	logic [31:0] pos_ff, pos_last_ff, abs_last_ff;
	logic [31:0] period_cnt_ff, edge_cnt_ff, wait_cnt_ff, idle_cnt_ff;
	logic idle_armed_ff;
	logic slow_ff;
	logic [47:0] div_num_ff;
	logic [32:0] div_rem_ff;
	logic [31:0] div_den_ff;
	logic [5:0] div_step_ff;
	logic div_busy_ff, div_neg_ff;

	// bus decode
	logic wr_acc, rd_acc, addr_ok;
	logic [7:0] idx;
	logic [31:0] rd_mux;
	assign idx = PADDR_IN[9:2];
	assign wr_acc = PSEL_IN & PENABLE_IN & pready_ff & PWRITE_IN;
	assign rd_acc = PSEL_IN & PENABLE_IN & ~pready_ff & ~PWRITE_IN;

	always_comb begin
		addr_ok = (PADDR_IN[11:10] == 2'h0) && (PADDR_IN[1:0] == 2'h0);
		rd_mux = 32'h0000_0000;
		case (idx)
			evf_pkg::IDX_IDLE_TIMEOUT: rd_mux = idle_timeout_ff;
			evf_pkg::IDX_FILTER_CFG: rd_mux = filter_cfg_ff;
			evf_pkg::IDX_RAW_SPEED: rd_mux = raw_speed_ff;
			evf_pkg::IDX_SMOOTH_SPEED: rd_mux = smooth_speed_ff;
			evf_pkg::IDX_EVENT_STATUS: rd_mux = status_ff;
			evf_pkg::IDX_EVENT_MASK: rd_mux = mask_ff;
			evf_pkg::IDX_ENC_MODE: rd_mux = mode_ff;
			evf_pkg::IDX_POLL_PERIOD: rd_mux = poll_period_ff;
			default: addr_ok = 1'b0;
		endcase
	end

	// apb answer: one wait state so ready and data come from flops
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= evf_pkg::RST_ZERO;
		end else begin
			pready_ff <= PSEL_IN & PENABLE_IN & ~pready_ff;
			pslverr_ff <= PSEL_IN & PENABLE_IN & ~pready_ff & ~addr_ok;
			if (rd_acc)
				prdata_ff <= addr_ok ? rd_mux : 32'h0000_0000;
		end
	end

	// writable configuration; speeds are read only
	logic wr_ok;
	assign wr_ok = wr_acc & ~pslverr_ff;
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			idle_timeout_ff <= evf_pkg::RST_IDLE_TIMEOUT;
			filter_cfg_ff <= evf_pkg::RST_FILTER_CFG;
			mask_ff <= evf_pkg::RST_ZERO;
			mode_ff <= evf_pkg::RST_ZERO;
			poll_period_ff <= evf_pkg::RST_POLL_PERIOD;
		end else if (wr_ok) begin
			case (idx)
				evf_pkg::IDX_IDLE_TIMEOUT: idle_timeout_ff <= PWDATA_IN;
				evf_pkg::IDX_FILTER_CFG: filter_cfg_ff <= PWDATA_IN;
				evf_pkg::IDX_EVENT_MASK:
					mask_ff <= {31'h0, PWDATA_IN[evf_pkg::EVT_IDLE_BIT]};
				evf_pkg::IDX_ENC_MODE:
					mode_ff <= {31'h0, PWDATA_IN[evf_pkg::MODE_ABS_BIT]};
				evf_pkg::IDX_POLL_PERIOD: poll_period_ff <= PWDATA_IN;
				default: ;
			endcase
		end
	end

	// configuration fields
	logic abs_mode;
	logic [7:0] cfg_wait;
	logic [3:0] cfg_shift;
	logic [15:0] cfg_period;
	logic [31:0] upd_period, sample_wait;
	assign abs_mode = mode_ff[evf_pkg::MODE_ABS_BIT];
	assign cfg_wait =
		filter_cfg_ff[evf_pkg::WAIT_MSB:evf_pkg::WAIT_LSB];
	assign cfg_shift =
		filter_cfg_ff[evf_pkg::SHIFT_MSB:evf_pkg::SHIFT_LSB];
	assign cfg_period =
		filter_cfg_ff[evf_pkg::PERIOD_MSB:evf_pkg::PERIOD_LSB];

	// the wait field is trusted above 32 cycles; smaller values still run
	always_comb begin
		if (abs_mode) begin
			upd_period = poll_period_ff;
			sample_wait = poll_period_ff;
		end else begin
			upd_period = ({16'h0, cfg_period} < evf_pkg::MIN_INC_PERIOD) ?
				evf_pkg::MIN_INC_PERIOD : {16'h0, cfg_period};
			sample_wait = {24'h0, cfg_wait};
		end
		if (upd_period == 32'h0)
			upd_period = 32'h0000_0001;
		if (sample_wait == 32'h0)
			sample_wait = 32'h0000_0001;
	end

	// pin synchronisers; stage 0 is read only by stage 1
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			a_sync_ff <= 3'h0;
			b_sync_ff <= 3'h0;
		end else begin
			a_sync_ff <= {a_sync_ff[1:0], ENC_A_IN};
			b_sync_ff <= {b_sync_ff[1:0], ENC_B_IN};
		end
	end

	// quadrature decode; a double change is dropped as a glitch
	logic a_chg, b_chg, ab_step, step_up;
	assign a_chg = a_sync_ff[2] ^ a_sync_ff[1];
	assign b_chg = b_sync_ff[2] ^ b_sync_ff[1];
	assign ab_step = (a_chg ^ b_chg) & ~abs_mode;
	assign step_up = a_sync_ff[2] ^ b_sync_ff[1];

	// position counting and per-period delta
	logic period_tick;
	logic [31:0] cur_pos, delta, delta_mag;
	assign period_tick = abs_mode ? ABS_POS_VALID_IN :
		(period_cnt_ff >= upd_period - 32'h1);
	assign cur_pos = abs_mode ? ABS_POS_IN : pos_ff;
	assign delta = cur_pos - (abs_mode ? abs_last_ff : pos_last_ff);
	assign delta_mag = delta[31] ? (32'h0 - delta) : delta;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			pos_ff <= evf_pkg::RST_ZERO;
			pos_last_ff <= evf_pkg::RST_ZERO;
			abs_last_ff <= evf_pkg::RST_ZERO;
			period_cnt_ff <= evf_pkg::RST_ZERO;
			slow_ff <= 1'b1;
		end else begin
			if (ab_step)
				pos_ff <= step_up ? pos_ff + 32'h1 : pos_ff - 32'h1;
			if (period_tick) begin
				period_cnt_ff <= 32'h0;
				pos_last_ff <= pos_ff;
				slow_ff <= (delta_mag <= 32'h1); // closing period was slow
				if (abs_mode)
					abs_last_ff <= ABS_POS_IN;
			end else begin
				period_cnt_ff <= period_cnt_ff + 32'h1;
			end
		end
	end

	// cycles since the last transition, saturating
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN)
			edge_cnt_ff <= 32'hffff_ffff;
		else if (ab_step)
			edge_cnt_ff <= 32'h1;
		else if (edge_cnt_ff != 32'hffff_ffff)
			edge_cnt_ff <= edge_cnt_ff + 32'h1;
	end

	// divider start: fast and absolute moves per period, slow incremental moves per transition
	logic hi_start, lo_start;
	assign hi_start = period_tick & (abs_mode | (delta_mag > 32'h1));
	// judged on the last whole period, so the first steps of a fresh period
	// at speed still take the slow path when the period before was slow
	assign lo_start = ab_step & ~hi_start & slow_ff &
		(edge_cnt_ff != 32'hffff_ffff);

	// restoring divider; a transition during a busy divide is skipped
	logic [32:0] trial;
	logic [30:0] quo_clip;
	assign trial = {div_rem_ff[31:0], div_num_ff[47]};
	assign quo_clip = (div_num_ff[47:31] != 17'h0) ? 31'h7fff_ffff :
		div_num_ff[30:0];
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			div_busy_ff <= 1'b0;
			div_neg_ff <= 1'b0;
			div_step_ff <= 6'h0;
			div_num_ff <= 48'h0;
			div_rem_ff <= 33'h0;
			div_den_ff <= evf_pkg::RST_ZERO;
			raw_speed_ff <= evf_pkg::RST_ZERO;
		end else if (!div_busy_ff && (hi_start || lo_start)) begin
			div_busy_ff <= 1'b1;
			div_step_ff <= 6'h0;
			div_rem_ff <= 33'h0;
			if (hi_start) begin
				div_neg_ff <= delta[31];
				div_num_ff <= 48'(delta_mag[15:0] * evf_pkg::CLK_HZ_W);
				div_den_ff <= abs_mode ? upd_period : upd_period;
			end else begin
				div_neg_ff <= ~step_up;
				div_num_ff <= evf_pkg::CLK_HZ_W;
				div_den_ff <= edge_cnt_ff;
			end
		end else if (div_busy_ff) begin
			if (div_step_ff == 6'(evf_pkg::DIV_STEPS)) begin
				div_busy_ff <= 1'b0;
				raw_speed_ff <= div_neg_ff ? 32'h0 - {1'b0, quo_clip} :
					{1'b0, quo_clip};
			end else begin
				div_step_ff <= div_step_ff + 6'h1;
				if (trial >= {1'b0, div_den_ff}) begin
					div_rem_ff <= trial - {1'b0, div_den_ff};
					div_num_ff <= {div_num_ff[46:0], 1'b1};
				end else begin
					div_rem_ff <= trial;
					div_num_ff <= {div_num_ff[46:0], 1'b0};
				end
			end
		end
	end

	// recursive mean; shifts are arithmetic so negative speeds settle
	logic signed [31:0] mean_s, raw_s, mean_nxt;
	assign mean_s = signed'(smooth_speed_ff);
	assign raw_s = signed'(raw_speed_ff);
	assign mean_nxt = mean_s - (mean_s >>> cfg_shift) +
		(raw_s >>> cfg_shift);
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			wait_cnt_ff <= evf_pkg::RST_ZERO;
			smooth_speed_ff <= evf_pkg::RST_ZERO;
		end else if (wait_cnt_ff >= sample_wait - 32'h1) begin
			wait_cnt_ff <= 32'h0;
			smooth_speed_ff <= unsigned'(mean_nxt);
		end else begin
			wait_cnt_ff <= wait_cnt_ff + 32'h1;
		end
	end

	// idle watchdog fires once per quiet spell; zero timeout disables it
	logic idle_hit;
	assign idle_hit = idle_armed_ff && (idle_timeout_ff != 32'h0) &&
		(idle_cnt_ff >= idle_timeout_ff - 32'h1) && !ab_step;
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			idle_cnt_ff <= evf_pkg::RST_ZERO;
			idle_armed_ff <= 1'b1;
		end else if (ab_step) begin
			idle_cnt_ff <= 32'h0;
			idle_armed_ff <= 1'b1;
		end else if (idle_hit) begin
			idle_armed_ff <= 1'b0;
		end else if (idle_armed_ff) begin
			idle_cnt_ff <= idle_cnt_ff + 32'h1;
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	logic clr_idle;
	assign clr_idle = wr_ok && (idx == evf_pkg::IDX_EVENT_STATUS) &&
		PWDATA_IN[evf_pkg::EVT_IDLE_BIT];
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN)
			status_ff <= evf_pkg::RST_ZERO;
		else if (idle_hit)
			status_ff <= {31'h0, 1'b1};
		else if (clr_idle)
			status_ff <= 32'h0;
	end

	// interrupt level, one cycle behind the status flop
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(status_ff & mask_ff);
	end

	assign PREADY_OUT = pready_ff;
	assign PRDATA_OUT = prdata_ff;
	assign PSLVERR_OUT = pslverr_ff;
	assign IRQ_OUT = irq_ff;
endmodule

//--- tb/evf_core_properties.sv
/* evf_core_properties: bus and interrupt checks on the evf_core ports.
   Assumes the bind below and a master that holds each request. */
`timescale 1ns/10ps
module evf_core_properties (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic PREADY_OUT,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic IRQ_OUT
);
	// single domain; reset silences every check
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	ready_one_cycle_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held too long");
	ready_one_wait_a: assert property (
		$rose(PENABLE_IN) && PSEL_IN |=> PREADY_OUT)
		else $error("ready not after one wait state");
	ready_needs_access_a: assert property (
		PREADY_OUT |-> PSEL_IN && PENABLE_IN && $past(PENABLE_IN))
		else $error("ready outside access phase");
	error_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	unmapped_error_a: assert property (
		PREADY_OUT && PADDR_IN == 12'h190 |-> PSLVERR_OUT)
		else $error("unmapped access not refused");
	error_reads_zero_a: assert property (
		PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0000_0000)
		else $error("refused read not zero");
	rdata_holds_a: assert property (
		$changed(PRDATA_OUT) |-> PREADY_OUT && !PWRITE_IN)
		else $error("read data moved without a read");
	irq_masked_off_a: assert property (
		PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h1c4 && !PWDATA_IN[0]
		|-> ##2 !IRQ_OUT)
		else $error("interrupt high while masked");
endmodule

bind evf_core evf_core_properties chk_i (.CLK_IN(CLK_IN),
	.RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
	.PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT));

//--- tb/evf_enc_model.sv
/* evf_enc_model: quadrature encoder with an absolute position strobe.
   Assumes the bench sets run, direction and step gap after clock edges. */
`timescale 1ns/10ps
module evf_enc_model (
	input wire logic clk_in,
	input wire logic run_in,
	input wire logic dir_in,
	input wire logic [15:0] gap_in,
	output logic a_out,
	output logic b_out,
	output logic [31:0] pos_out,
	output logic valid_out
);
	logic [15:0] cnt_ff = 16'h0000;
	logic [1:0] ph_ff = 2'h0;
	initial pos_out = 32'h0000_0000;
	initial valid_out = 1'b0;
	// one gray step per gap; pins hold while stopped so idle is real
	always @(posedge clk_in) begin
		valid_out <= 1'b0;
		if (run_in && cnt_ff >= gap_in - 16'h0001) begin
			cnt_ff <= 16'h0000;
			ph_ff <= dir_in ? ph_ff - 2'h1 : ph_ff + 2'h1;
			pos_out <= dir_in ? pos_out - 32'h1 : pos_out + 32'h1;
			valid_out <= 1'b1;
		end else if (run_in) begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end
	// 00,01,11,10 counts up; exactly one pin changes per step
	assign a_out = ph_ff[1];
	assign b_out = ph_ff[1] ^ ph_ff[0];
endmodule

//--- tb/evf_core_tb.sv
/* evf_core_tb: register level tests of the encoder velocity filter.
   Assumes the design, the encoder model and the checker compiled first. */
`timescale 1ns/10ps
module evf_core_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic pready, pslverr, irq, enc_a, enc_b, abs_vld, err;
	logic [31:0] prdata, abs_pos, q;
	logic run = 1'b0;
	logic dir = 1'b0;
	logic [15:0] gap = 16'h03e8;
	logic [15:0] per_t[2] = '{16'h0010, 16'h0200};
	logic [31:0] hi_t[2] = '{32'h0026_25a0, 32'h0024_f473};
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	// 40 MHz
	always #12.5 clk = ~clk;
	evf_core uut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
		.PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .ENC_A_IN(enc_a),
		.ENC_B_IN(enc_b), .ABS_POS_IN(abs_pos), .ABS_POS_VALID_IN(abs_vld));
	evf_enc_model enc (.clk_in(clk), .run_in(run), .dir_in(dir),
		.gap_in(gap), .a_out(enc_a), .b_out(enc_b), .pos_out(abs_pos),
		.valid_out(abs_vld));
	task finish_test();
		if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			finish_test();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected %0t: got %h want %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// full APB transfer; ready is waited for, never counted on
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rdc(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(q, exp);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// main sequence; incremental runs both ways, then absolute mode
	initial begin
		tick(4);
		rst_n <= 1'b1;
		rdc(evf_pkg::IDX_FILTER_CFG, evf_pkg::RST_FILTER_CFG);
		rdc(evf_pkg::IDX_IDLE_TIMEOUT, evf_pkg::RST_IDLE_TIMEOUT);
		rdc(evf_pkg::IDX_POLL_PERIOD, evf_pkg::RST_POLL_PERIOD);
		rdc(evf_pkg::IDX_SMOOTH_SPEED, evf_pkg::RST_ZERO);
		apb(1'b1, evf_pkg::IDX_RAW_SPEED, 32'h0000_1234);
		rdc(evf_pkg::IDX_RAW_SPEED, evf_pkg::RST_ZERO);
		rdc(8'h64, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		apb(1'b1, evf_pkg::IDX_IDLE_TIMEOUT, 32'h0000_07d0);
		run <= 1'b1;
		tick(6000);
		rdc(evf_pkg::IDX_RAW_SPEED, 32'h0000_9c40);
		tick(8000);
		apb(1'b0, evf_pkg::IDX_SMOOTH_SPEED, 32'h0000_0000);
		chk({4'h0, q[31:4]}, 32'h0000_09c4);
		rdc(evf_pkg::IDX_EVENT_STATUS, 32'h0000_0000);
		apb(1'b1, evf_pkg::IDX_FILTER_CFG, 32'h0100_0040);
		dir <= 1'b1;
		tick(4000);
		rdc(evf_pkg::IDX_RAW_SPEED, 32'hffff_63c0);
		rdc(evf_pkg::IDX_SMOOTH_SPEED, 32'hffff_63c0);
		run <= 1'b0;
		tick(2100);
		rdc(evf_pkg::IDX_EVENT_STATUS, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, evf_pkg::IDX_EVENT_MASK, 32'h0000_0001);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0001);
		rdc(evf_pkg::IDX_RAW_SPEED, 32'hffff_63c0);
		apb(1'b1, evf_pkg::IDX_EVENT_STATUS, 32'h0000_0001);
		rdc(evf_pkg::IDX_EVENT_STATUS, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		// short periods are clamped up; longer ones are used as set
		dir <= 1'b0;
		gap <= 16'h0011;
		run <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, evf_pkg::IDX_FILTER_CFG, {per_t[i], 16'h0440});
			tick(3000);
			apb(1'b0, evf_pkg::IDX_RAW_SPEED, 32'h0000_0000);
			chk({31'h0, q == 32'h0023_c346 || q == hi_t[i]}, 32'h1);
		end
		// absolute mode divides by the poll period; the model is polled
		// at that same rate, as a serial encoder would be
		gap <= 16'h0200;
		apb(1'b1, evf_pkg::IDX_ENC_MODE, 32'h0000_0001);
		apb(1'b1, evf_pkg::IDX_POLL_PERIOD, 32'h0000_0200);
		tick(2000);
		rdc(evf_pkg::IDX_RAW_SPEED, 32'h0001_312d);
		apb(1'b1, evf_pkg::IDX_EVENT_MASK, 32'h0000_0000);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0000);
		finish_test();
	end
endmodule
